// [asdt_top.sv]
// asdt_top: passive audio serial decoder and trigger, wishbone configured
// assumes bus channels are asynchronous pins sampled at 40 MHz, bit clock well below 10 MHz
// Function
// - watch clock, select, data from four channels
// - i2s, left, right justified and tdm
// - stereo word length 4..32, default 4
// - sample data on chosen clock edge
// - select polarity swaps left and right
// - data polarity high means one or zero
// - lsb_first or msb_first assembly, lsb default
// - tdm data bits per slot 4..32
// - tdm slot length 4..32 clocks
// - tdm slots per frame 2..64
// - tdm bit delay 0..31 after sync
// - tdm frame start on chosen sync edge
// - stereo sources: select event or data
// - tdm sources: frame sync or data
// - eight data comparison conditions
// - stereo data trigger either, left, right
// - tdm data trigger on one slot
// - disabled decoder yields no words
`timescale 1ns/1ps
module asdt_top import asdt_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // probe channels
    input wire logic [3:0] chan_i,
    // decoded stream and trigger
    output logic word_vld_o,
    output logic [31:0] word_o,
    output logic word_right_o,
    output logic [5:0] word_slot_o,
    output logic trig_o
);
    logic [31:0] ctrl_ff, wlen_ff, tdm_ff, trig_ff, vlo_ff, vhi_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [3:0] s1_ff, s2_ff;
    logic clk_old_ff, lr_old_ff;
    logic [31:0] sh_ff;
    logic [5:0] bcnt_ff;
    logic [5:0] slot_ff;
    logic [5:0] dly_ff;
    logic in_frame_ff;
    logic cur_right_ff;
    logic vld_ff, right_ff, evt_ff;
    logic [31:0] word_ff;
    logic [5:0] wslot_ff;
    logic [31:0] nwords_ff;
    logic hit;

    // clamp a programmed length to its legal range
    function automatic logic [5:0] clamp_len(input logic [5:0] v);
        if (v < ASDT_LEN_MIN) begin
            return ASDT_LEN_MIN;
        end else if (v > ASDT_LEN_MAX) begin
            return ASDT_LEN_MAX;
        end
        return v;
    endfunction : clamp_len

    function automatic logic [31:0] wr_mask(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wr_mask

    // configuration fields
    logic en;
    logic [1:0] fmt;
    logic tdm;
    logic [5:0] wlen, slen;
    logic [6:0] nslot;
    logic [4:0] bdelay;
    logic [5:0] tslot;
    assign en = ctrl_ff[ASDT_EN_BIT];
    assign fmt = ctrl_ff[ASDT_FMT_LSB +: 2];
    assign tdm = (fmt == ASDT_FMT_TDM);
    assign wlen = clamp_len(wlen_ff[5:0]);
    assign slen = clamp_len(tdm_ff[ASDT_SLOTLEN_LSB +: 6]);
    assign nslot = (tdm_ff[ASDT_NSLOT_LSB +: 7] < ASDT_NSLOT_MIN) ? ASDT_NSLOT_MIN :
                   (tdm_ff[ASDT_NSLOT_LSB +: 7] > ASDT_NSLOT_MAX) ? ASDT_NSLOT_MAX :
                   tdm_ff[ASDT_NSLOT_LSB +: 7];
    assign bdelay = tdm_ff[ASDT_DELAY_LSB +: 5];
    assign tslot = tdm_ff[ASDT_TSLOT_LSB +: 6];

    // wishbone: ack one cycle after request, dropped the next cycle
    logic req;
    assign req = cyc_i && stb_i && !ack_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (req) begin
                if (adr_i == ASDT_CTRL_OFF) begin
                    rdat_ff <= ctrl_ff;
                end else if (adr_i == ASDT_WORD_OFF) begin
                    rdat_ff <= wlen_ff;
                end else if (adr_i == ASDT_TDM_OFF) begin
                    rdat_ff <= tdm_ff;
                end else if (adr_i == ASDT_TRIG_OFF) begin
                    rdat_ff <= trig_ff;
                end else if (adr_i == ASDT_VLO_OFF) begin
                    rdat_ff <= vlo_ff;
                end else if (adr_i == ASDT_VHI_OFF) begin
                    rdat_ff <= vhi_ff;
                end else if (adr_i == ASDT_STAT_OFF) begin
                    rdat_ff <= nwords_ff;
                end else if (adr_i == ASDT_LAST_OFF) begin
                    rdat_ff <= word_ff;
                end else begin
                    rdat_ff <= 32'h0000_0000;
                end
            end
        end
    end
    assign ack_o = ack_ff;
    assign dat_o = rdat_ff;

    // writes land at the edge that ends ack, while ack is still high
    logic wr;
    assign wr = cyc_i && stb_i && we_i && ack_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= ASDT_CTRL_RST;
            wlen_ff <= {26'h0, ASDT_LEN_RST};
            tdm_ff <= {2'h0, ASDT_TSLOT_RST, 3'h0, ASDT_DELAY_RST, 1'h0, ASDT_NSLOT_RST,
                       2'h0, ASDT_LEN_RST};
            trig_ff <= {26'h0, ASDT_LEN_RST};
            vlo_ff <= 32'h0000_0000;
            vhi_ff <= 32'h0000_0000;
        end else if (wr) begin
            if (adr_i == ASDT_CTRL_OFF) begin
                ctrl_ff <= wr_mask(ctrl_ff, dat_i, sel_i);
            end else if (adr_i == ASDT_WORD_OFF) begin
                wlen_ff <= wr_mask(wlen_ff, dat_i, sel_i);
            end else if (adr_i == ASDT_TDM_OFF) begin
                tdm_ff <= wr_mask(tdm_ff, dat_i, sel_i);
            end else if (adr_i == ASDT_TRIG_OFF) begin
                trig_ff <= wr_mask(trig_ff, dat_i, sel_i);
            end else if (adr_i == ASDT_VLO_OFF) begin
                vlo_ff <= wr_mask(vlo_ff, dat_i, sel_i);
            end else if (adr_i == ASDT_VHI_OFF) begin
                vhi_ff <= wr_mask(vhi_ff, dat_i, sel_i);
            end
        end
    end

    // two-flop synchronisers, then channel routing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
        end else begin
            s1_ff <= chan_i;
            s2_ff <= s1_ff;
        end
    end
    logic bclk, lrs, sdat;
    assign bclk = s2_ff[ctrl_ff[ASDT_CLK_LSB +: 2]];
    assign lrs = s2_ff[ctrl_ff[ASDT_LR_LSB +: 2]];
    assign sdat = s2_ff[ctrl_ff[ASDT_DAT_LSB +: 2]] ^ ctrl_ff[ASDT_DINV_BIT];

    logic samp, lr_edge, sync_edge;
    assign samp = ctrl_ff[ASDT_FALL_BIT] ? (clk_old_ff && !bclk)
                                          : (!clk_old_ff && bclk);
    assign lr_edge = samp && (lrs != lr_old_ff);
    assign sync_edge = samp && (ctrl_ff[ASDT_SYNCF_BIT] ? (lr_old_ff && !lrs)
                                                        : (!lr_old_ff && lrs));

    // i2s data starts one clock after select edge; justified formats start at once
    logic new_word;
    logic [5:0] skip;
    assign new_word = tdm ? sync_edge : lr_edge;
    assign skip = tdm ? {1'b0, bdelay} : (fmt == ASDT_FMT_I2S) ? 6'h01 : 6'h00;

    logic bit_take, slot_end, word_full;
    assign bit_take = samp && in_frame_ff && (dly_ff == 6'h00);
    assign word_full = (bcnt_ff + 6'h01 == wlen);
    assign slot_end = tdm && bit_take && (bcnt_ff + 6'h01 == slen);

    // right justified: keep last wlen bits before select change
    logic rj;
    assign rj = (fmt == ASDT_FMT_RIGHT_JUST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_old_ff <= 1'b0;
            lr_old_ff <= 1'b0;
            sh_ff <= 32'h0000_0000;
            bcnt_ff <= 6'h00;
            slot_ff <= 6'h00;
            dly_ff <= 6'h00;
            in_frame_ff <= 1'b0;
            cur_right_ff <= 1'b0;
            vld_ff <= 1'b0;
            word_ff <= 32'h0000_0000;
            right_ff <= 1'b0;
            wslot_ff <= 6'h00;
            evt_ff <= 1'b0;
            nwords_ff <= 32'h0000_0000;
        end else begin
            clk_old_ff <= bclk;
            if (samp) begin
                lr_old_ff <= lrs;
            end
            vld_ff <= 1'b0;
            evt_ff <= en && new_word;
            if (!en) begin
                in_frame_ff <= 1'b0;
            end else if (new_word) begin
                if (rj && in_frame_ff) begin
                    vld_ff <= 1'b1;
                    word_ff <= ctrl_ff[ASDT_MSB_BIT] ? sh_ff
                             : sh_ff >> (6'h20 - wlen);
                    right_ff <= cur_right_ff;
                    nwords_ff <= nwords_ff + 32'h0000_0001;
                end
                in_frame_ff <= 1'b1;
                // with no skip the bit on the edge is the first of the new word
                bcnt_ff <= (skip == 6'h00) ? 6'h01 : 6'h00;
                slot_ff <= 6'h00;
                sh_ff <= (skip != 6'h00) ? 32'h0000_0000
                       : (rj && !ctrl_ff[ASDT_MSB_BIT]) ? {sdat, 31'h0000_0000}
                       : {31'h0000_0000, sdat};
                dly_ff <= (skip == 6'h00) ? 6'h00 : skip - 6'h01;
                cur_right_ff <= lrs ^ ctrl_ff[ASDT_LRINV_BIT];
            end else if (samp && in_frame_ff && dly_ff != 6'h00) begin
                dly_ff <= dly_ff - 6'h01;
            end else if (bit_take) begin
                if (rj) begin
                    sh_ff <= ctrl_ff[ASDT_MSB_BIT] ? {sh_ff[30:0], sdat} & ~(32'hFFFF_FFFF << wlen)
                                                   : {sdat, sh_ff[31:1]};
                end else if (bcnt_ff < wlen) begin
                    if (ctrl_ff[ASDT_MSB_BIT]) begin
                        sh_ff <= {sh_ff[30:0], sdat};
                    end else begin
                        sh_ff[bcnt_ff[4:0]] <= sdat;
                    end
                    if (word_full) begin
                        vld_ff <= 1'b1;
                        word_ff <= ctrl_ff[ASDT_MSB_BIT] ? {sh_ff[30:0], sdat}
                                 : (sh_ff | (32'h0000_0001 << bcnt_ff[4:0]) & {32{sdat}});
                        right_ff <= cur_right_ff;
                        wslot_ff <= slot_ff;
                        nwords_ff <= nwords_ff + 32'h0000_0001;
                    end
                end
                if (!rj) begin
                    bcnt_ff <= (bcnt_ff == 6'h3F) ? bcnt_ff : bcnt_ff + 6'h01;
                end
                if (slot_end) begin
                    bcnt_ff <= 6'h00;
                    sh_ff <= 32'h0000_0000;
                    if ({1'b0, slot_ff} + 7'h01 == nslot) begin
                        in_frame_ff <= 1'b0;
                    end else begin
                        slot_ff <= slot_ff + 6'h01;
                    end
                end
            end
        end
    end

    // slot or side filter sits before the comparator
    logic side_ok;
    always_comb begin
        side_ok = 1'b1;
        if (tdm) begin
            side_ok = (wslot_ff == tslot);
        end else if (trig_ff[ASDT_SIDE_LSB +: 2] == ASDT_SIDE_LEFT) begin
            side_ok = !right_ff;
        end else if (trig_ff[ASDT_SIDE_LSB +: 2] == ASDT_SIDE_RIGHT) begin
            side_ok = right_ff;
        end
    end

    asdt_cmp u_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .word_vld_i(vld_ff && side_ok),
        .word_i(word_ff),
        .cond_i(trig_ff[ASDT_COND_LSB +: 3]),
        .lo_i(vlo_ff),
        .hi_i(vhi_ff),
        .hit_o(hit)
    );

    logic trig_q_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_q_ff <= 1'b0;
        end else begin
            trig_q_ff <= trig_ff[ASDT_SRC_BIT] ? hit : evt_ff;
        end
    end
    assign trig_o = trig_q_ff;
    assign word_vld_o = vld_ff;
    assign word_o = word_ff;
    assign word_right_o = right_ff;
    assign word_slot_o = wslot_ff;
endmodule : asdt_top

// [asdt_pkg.sv]
// asdt_pkg: register map, field layout, reset values and encodings of the audio decode trigger
// assumes a 32-bit classic wishbone register bus
package asdt_pkg;
    // register byte offsets
    localparam logic [7:0] ASDT_CTRL_OFF = 8'h00;
    localparam logic [7:0] ASDT_WORD_OFF = 8'h04;
    localparam logic [7:0] ASDT_TDM_OFF = 8'h08;
    localparam logic [7:0] ASDT_TRIG_OFF = 8'h0C;
    localparam logic [7:0] ASDT_VLO_OFF = 8'h10;
    localparam logic [7:0] ASDT_VHI_OFF = 8'h14;
    localparam logic [7:0] ASDT_STAT_OFF = 8'h18;
    localparam logic [7:0] ASDT_LAST_OFF = 8'h1C;
    // control field positions
    localparam int ASDT_EN_BIT = 0;
    localparam int ASDT_FMT_LSB = 1;
    localparam int ASDT_FALL_BIT = 3;
    localparam int ASDT_LRINV_BIT = 4;
    localparam int ASDT_DINV_BIT = 5;
    localparam int ASDT_MSB_BIT = 6;
    localparam int ASDT_SYNCF_BIT = 7;
    localparam int ASDT_CLK_LSB = 8;
    localparam int ASDT_LR_LSB = 10;
    localparam int ASDT_DAT_LSB = 12;
    // tdm register fields
    localparam int ASDT_SLOTLEN_LSB = 0;
    localparam int ASDT_NSLOT_LSB = 8;
    localparam int ASDT_DELAY_LSB = 16;
    localparam int ASDT_TSLOT_LSB = 24;
    // trigger register fields
    localparam int ASDT_SRC_BIT = 0;
    localparam int ASDT_COND_LSB = 1;
    localparam int ASDT_SIDE_LSB = 4;
    // reset values
    localparam logic [31:0] ASDT_CTRL_RST = 32'h0000_0000;
    localparam logic [5:0] ASDT_LEN_RST = 6'h04;
    localparam logic [6:0] ASDT_NSLOT_RST = 7'h02;
    localparam logic [4:0] ASDT_DELAY_RST = 5'h00;
    localparam logic [5:0] ASDT_TSLOT_RST = 6'h00;
    // limits
    localparam logic [5:0] ASDT_LEN_MIN = 6'h04;
    localparam logic [5:0] ASDT_LEN_MAX = 6'h20;
    localparam logic [6:0] ASDT_NSLOT_MIN = 7'h02;
    localparam logic [6:0] ASDT_NSLOT_MAX = 7'h40;
    typedef enum logic [1:0] {
        ASDT_FMT_I2S = 2'h0,
        ASDT_FMT_LEFT_JUST = 2'h1,
        ASDT_FMT_RIGHT_JUST = 2'h2,
        ASDT_FMT_TDM = 2'h3
    } asdt_fmt_t;
    typedef enum logic [2:0] {
        ASDT_EQ = 3'h0, ASDT_NE = 3'h1, ASDT_LT = 3'h2, ASDT_GT = 3'h3,
        ASDT_LE = 3'h4, ASDT_GE = 3'h5, ASDT_IN = 3'h6, ASDT_OUT = 3'h7
    } asdt_cond_t;
    localparam logic [1:0] ASDT_SIDE_EITHER = 2'h0;
    localparam logic [1:0] ASDT_SIDE_LEFT = 2'h1;
    localparam logic [1:0] ASDT_SIDE_RIGHT = 2'h2;
endpackage : asdt_pkg

// [asdt_cmp.sv]
// asdt_cmp: registered value comparator for the data trigger
// assumes value and bounds arrive with word_vld on the same clock
`timescale 1ns/1ps
module asdt_cmp import asdt_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // word in
    input wire logic word_vld_i,
    input wire logic [31:0] word_i,
    // setup
    input wire logic [2:0] cond_i,
    input wire logic [31:0] lo_i,
    input wire logic [31:0] hi_i,
    // result
    output logic hit_o
);
    logic hit_ff;
    logic nxt_hit;
    always_comb begin
        nxt_hit = 1'b0;
        if (word_vld_i) begin
            case (cond_i)
                ASDT_EQ: nxt_hit = (word_i == lo_i);
                ASDT_NE: nxt_hit = (word_i != lo_i);
                ASDT_LT: nxt_hit = (word_i < lo_i);
                ASDT_GT: nxt_hit = (word_i > lo_i);
                ASDT_LE: nxt_hit = (word_i <= lo_i);
                ASDT_GE: nxt_hit = (word_i >= lo_i);
                ASDT_IN: nxt_hit = (word_i >= lo_i) && (word_i <= hi_i);
                default: nxt_hit = (word_i < lo_i) || (word_i > hi_i);
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_ff <= 1'b0;
        end else begin
            hit_ff <= nxt_hit;
        end
    end
    assign hit_o = hit_ff;
endmodule : asdt_cmp

// [asdt_chk.sv]
// asdt_chk: port-level assertions for asdt_top
// assumes full-word register writes (sel_i all ones) and one clock domain
`timescale 1ns/1ps
module asdt_chk import asdt_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // decoded stream and trigger
    input wire logic word_vld_o,
    input wire logic [31:0] word_o,
    input wire logic word_right_o,
    input wire logic [5:0] word_slot_o,
    input wire logic trig_o
);
    logic [31:0] ctrl_ff, trg_ff, tdm_ff, lo_ff;
    logic [5:0] len_ff;
    logic [6:0] nslot;
    logic wr;
    logic data_src;
    assign wr = cyc_i && stb_i && we_i && ack_o && (&sel_i);
    assign data_src = trg_ff[ASDT_SRC_BIT];
    // slot count below the minimum is taken as two
    assign nslot = (tdm_ff[14:8] < 7'h02) ? 7'h02 : tdm_ff[14:8];
    // shadow copy of setup, updated at the acked write edge like the block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= ASDT_CTRL_RST;
            trg_ff <= 32'h0;
            tdm_ff <= 32'h0000_0204;
            lo_ff <= 32'h0;
            len_ff <= ASDT_LEN_RST;
        end else if (wr) begin
            if (adr_i == ASDT_CTRL_OFF) ctrl_ff <= dat_i;
            if (adr_i == ASDT_TRIG_OFF) trg_ff <= dat_i;
            if (adr_i == ASDT_TDM_OFF) tdm_ff <= dat_i;
            if (adr_i == ASDT_VLO_OFF) lo_ff <= dat_i;
            if (adr_i == ASDT_WORD_OFF) begin
                len_ff <= (dat_i[5:0] < ASDT_LEN_MIN) ? ASDT_LEN_MIN :
                          (dat_i[5:0] > ASDT_LEN_MAX) ? ASDT_LEN_MAX : dat_i[5:0];
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_trig_pulse;
        trig_o |=> !trig_o;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than a cycle");
    property p_vld_pulse;
        word_vld_o |=> !word_vld_o;
    endproperty
    a_vld_pulse: assert property (p_vld_pulse) else $error("word strobe too wide");
    property p_off_quiet;
        !ctrl_ff[ASDT_EN_BIT] |-> !word_vld_o && !trig_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("output while disabled");
    property p_len_bound;
        word_vld_o |-> (word_o >> len_ff) == 32'h0;
    endproperty
    a_len_bound: assert property (p_len_bound) else $error("word wider than length");
    property p_slot_range;
        word_vld_o && ctrl_ff[2:1] == ASDT_FMT_TDM |-> {1'b0, word_slot_o} < nslot;
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("slot beyond frame");
    property p_data_trig;
        trig_o && data_src |-> $past(word_vld_o, 2);
    endproperty
    a_data_trig: assert property (p_data_trig) else $error("data trigger without word");
    property p_eq_trig;
        trig_o && data_src && trg_ff[3:1] == ASDT_EQ |-> $past(word_o, 2) == lo_ff;
    endproperty
    a_eq_trig: assert property (p_eq_trig) else $error("equal trigger on other value");
    property p_left_only;
        trig_o && data_src && ctrl_ff[2:1] != ASDT_FMT_TDM && trg_ff[5:4] == ASDT_SIDE_LEFT
            |-> !$past(word_right_o, 2);
    endproperty
    a_left_only: assert property (p_left_only) else $error("left-only trigger on right");
    property p_tdm_slot;
        trig_o && data_src && ctrl_ff[2:1] == ASDT_FMT_TDM
            |-> $past(word_slot_o, 2) == tdm_ff[29:24];
    endproperty
    a_tdm_slot: assert property (p_tdm_slot) else $error("trigger from other slot");
endmodule : asdt_chk

bind asdt_top asdt_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .word_vld_o(word_vld_o), .word_o(word_o), .word_right_o(word_right_o),
    .word_slot_o(word_slot_o), .trig_o(trig_o));

// [asdt_xmit.sv]
// asdt_xmit: behavioural audio serial transmitter on the probe pins
// assumes the bench hands each frame as per-clock select and data bits
`timescale 1ns/1ps
module asdt_xmit (
    // bus pins
    output logic bclk_o,
    output logic sel_o,
    output logic dat_o
);
    initial begin
        bclk_o = 1'b0;
        sel_o = 1'b1;
        dat_o = 1'b0;
    end
    // data held across both clock edges, so either sampling edge sees it
    task automatic send(input logic [63:0] ws, input logic [63:0] dt, input int n);
        // keep pin changes off the block's clock edges
        #6.25;
        for (int k = 0; k < n; k++) begin
            sel_o = ws[k];
            dat_o = dt[k];
            #50 bclk_o = 1'b1;
            #100 bclk_o = 1'b0;
            #50;
        end
        // clock stands low between frames; released data shows no stale bit
        dat_o = ~dat_o;
    endtask : send
endmodule : asdt_xmit

// [audio_serial_decode_trigger_tb.sv]
// audio_serial_decode_trigger_tb: directed bench for asdt_top with a transmitter model
// assumes wishbone answers within 20 cycles; clock ch0, select ch1, data ch2
`timescale 1ns/1ps
module audio_serial_decode_trigger_tb import asdt_pkg::*;;
    logic clk_i, rst_i, cyc, stb, we, ack, vld, rgt, trg, xclk, xsel, xdat;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, word, got;
    logic [5:0] slot;
    logic [38:0] cap[$];
    int mismatches, checked, trigs;

    asdt_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .chan_i({1'b0, xdat, xsel, xclk}), .word_vld_o(vld), .word_o(word),
        .word_right_o(rgt), .word_slot_o(slot), .trig_o(trg));
    asdt_xmit u_xmit (.bclk_o(xclk), .sel_o(xsel), .dat_o(xdat));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (vld === 1'b1) cap.push_back({slot, rgt, word});
        if (trg === 1'b1) trigs++;
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [38:0] e, input logic [38:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), {7'h0, e}, {7'h0, got});
    endtask : rd
    task automatic cfg(input logic [31:0] fl, input logic [31:0] tr, input logic [31:0] lo);
        wb(1'b1, ASDT_CTRL_OFF, 32'h0000_2400 | fl);
        wb(1'b1, ASDT_TRIG_OFF, tr);
        wb(1'b1, ASDT_VLO_OFF, lo);
    endtask : cfg
    task automatic frame(input logic [63:0] ws, input logic [63:0] dt, input int n);
        cap.delete();
        trigs = 0;
        u_xmit.send(ws, dt, n);
        // drain: words land a few cycles after the last bit
        repeat (40) @(posedge clk_i);
    endtask : frame
    // lead select slot, left then right words, closing select edge
    task automatic stereo(input bit lj, input logic [31:0] l, input logic [31:0] r,
                          input int nb, input logic [31:0] fl);
        logic [63:0] ws, dt;
        logic [31:0] w;
        int k;
        ws = '1;
        dt = '1;
        k = 1;
        for (int s = 0; s < 2; s++) begin
            w = s ? r : l;
            for (int j = lj ? 0 : -1; j < nb; j++) begin
                ws[k] = s[0];
                if (j >= 0 && j < 4) dt[k] = fl[6] ? w[3 - j] : w[j];
                k++;
            end
        end
        ws[k] = 1'b0;
        frame(ws ^ {64{fl[4]}}, dt ^ {64{fl[5]}}, k + 1);
    endtask : stereo
    // two slots of six clocks, four data bits each, lsb first
    task automatic tdm(input logic [31:0] w0, input logic [31:0] w1, input int dly,
                       input logic [31:0] fl);
        logic [63:0] ws, dt;
        ws = '0;
        dt = '1;
        ws[1] = 1'b1;
        for (int j = 0; j < 12; j++) begin
            if (j % 6 < 4) dt[1 + dly + j] = (j < 6) ? w0[j] : w1[j - 6];
        end
        frame(ws ^ {64{fl[7]}}, dt, 13 + dly);
    endtask : tdm
    // stereo compares right flag and word, tdm compares slot and word
    task automatic words(input int n, input logic [38:0] e0, input logic [38:0] e1,
                         input int nt, input bit t);
        logic [38:0] m;
        m = t ? 39'h7E_FFFF_FFFF : 39'h01_FFFF_FFFF;
        check("word count", 39'(n), 39'(cap.size()));
        check("trigger count", 39'(nt), 39'(trigs));
        if (cap.size() > 0) check("first word", e0 & m, cap[0] & m);
        if (cap.size() > 1) check("second word", e1 & m, cap[1] & m);
    endtask : words

    task automatic t_regs;
        rd(ASDT_CTRL_OFF, 32'h0);
        rd(ASDT_WORD_OFF, 32'h4);
        rd(ASDT_TDM_OFF, 32'h0000_0204);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
    endtask : t_regs
    task automatic t_i2s;
        cfg(32'h41, 32'h1, 32'h5);
        stereo(1'b0, 32'hA, 32'h5, 4, 32'h41);
        words(2, 39'h0_0000_000A, 39'h1_0000_0005, 1, 0);
        rd(ASDT_LAST_OFF, 32'h5);
    endtask : t_i2s
    task automatic t_lj;
        // six bits per side: the two beyond the length must be dropped
        cfg(32'h33, 32'h21, 32'hC);
        stereo(1'b1, 32'h3, 32'hC, 6, 32'h33);
        words(2, 39'h0_0000_0003, 39'h1_0000_000C, 1, 0);
    endtask : t_lj
    task automatic t_conds;
        logic [15:0] tbl;
        int sd;
        int ex;
        // per condition: left 0xA matches in odd bit, right 0x6 in even bit
        tbl = 16'h9D89;
        wb(1'b1, ASDT_VHI_OFF, 32'h8);
        for (int c = 0; c < 8; c++) begin
            sd = c % 3;
            ex = int'(sd != 2 && tbl[2 * c + 1]) + int'(sd != 1 && tbl[2 * c]);
            cfg(32'h09, 32'h1 | (c << 1) | (sd << 4), (c >= 6) ? 32'h4 : 32'h6);
            stereo(1'b0, 32'hA, 32'h6, 4, 32'h09);
            words(2, 39'h0_0000_000A, 39'h1_0000_0006, ex, 0);
        end
    endtask : t_conds
    task automatic t_tdm;
        wb(1'b1, ASDT_TDM_OFF, 32'h0101_0206);
        cfg(32'h07, 32'h7, 32'h3);
        tdm(32'h9, 32'h2, 1, 32'h07);
        words(2, 39'h00_0000_0009, 39'h02_0000_0002, 0, 1);
        tdm(32'h1, 32'hC, 1, 32'h07);
        words(2, 39'h00_0000_0001, 39'h02_0000_000C, 1, 1);
        wb(1'b1, ASDT_TDM_OFF, 32'h0100_0206);
        cfg(32'h87, 32'h0, 32'h0);
        tdm(32'h5, 32'hA, 0, 32'h87);
        words(2, 39'h00_0000_0005, 39'h02_0000_000A, 1, 1);
    endtask : t_tdm
    task automatic t_off;
        cfg(32'h0, 32'h3, 32'h0);
        stereo(1'b0, 32'hA, 32'h6, 4, 32'h0);
        words(0, 39'h0, 39'h0, 0, 0);
    endtask : t_off
    task automatic t_rj;
        // six clocks per side, last four kept; select event trigger on three edges
        cfg(32'h05, 32'h0, 32'h0);
        frame(64'h4_0FC0, 64'h1_B9C0, 19);
        words(2, 39'h1_0000_0009, 39'h0_0000_0006, 3, 0);
    endtask : t_rj

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'hF;
        wdat = 32'h0;
        mismatches = 0;
        checked = 0;
        trigs = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_i2s();
        t_lj();
        t_conds();
        t_tdm();
        t_off();
        t_rj();
        tally_and_finish();
    end
endmodule : audio_serial_decode_trigger_tb
